// [vic_pkg.sv]
package vic_pkg;

  // ****************************************
  // Source counts
  // ****************************************
  localparam int NUM_PERIPH = 16;
  localparam int NUM_EXT    = 5;
  localparam int NUM_SRC    = NUM_PERIPH + NUM_EXT;
  localparam int NUM_PRIO   = 4;
  localparam int SLOTS      = 4;
  localparam int NUM_EV     = 3;

  // ****************************************
  // Byte addresses (low 16 bits of haddr)
  // ****************************************
  localparam logic [15:0] OFF_CONTROL    = 16'h1000;
  localparam logic [15:0] OFF_STATUS     = 16'h1010;
  localparam logic [15:0] OFF_RELOAD     = 16'h1020;
  localparam logic [15:0] OFF_FLAGS      = 16'h1030;
  localparam logic [15:0] OFF_EVT_STATUS = 16'h1040;
  localparam logic [15:0] OFF_EVT_CLEAR  = 16'h1050;
  localparam logic [15:0] OFF_EVT_ENABLE = 16'h1060;
  localparam logic [15:0] OFF_PRIO_7     = 16'h1100;
  localparam logic [15:0] OFF_PRIO_8     = 16'h1110;
  localparam logic [15:0] OFF_PRIO_9     = 16'h1120;
  localparam logic [15:0] OFF_PRIO_10    = 16'h1130;

  // Alias selected by haddr[3:2]
  localparam logic [1:0] ALIAS_NONE = 2'h0;
  localparam logic [1:0] ALIAS_CLR  = 2'h1;
  localparam logic [1:0] ALIAS_SET  = 2'h2;
  localparam logic [1:0] ALIAS_INV  = 2'h3;

  // Internal register identifiers
  localparam logic [3:0] REG_CONTROL    = 4'h0;
  localparam logic [3:0] REG_STATUS     = 4'h1;
  localparam logic [3:0] REG_RELOAD     = 4'h2;
  localparam logic [3:0] REG_FLAGS      = 4'h3;
  localparam logic [3:0] REG_PRIO_7     = 4'h4;
  localparam logic [3:0] REG_PRIO_8     = 4'h5;
  localparam logic [3:0] REG_PRIO_9     = 4'h6;
  localparam logic [3:0] REG_PRIO_10    = 4'h7;
  localparam logic [3:0] REG_EVT_STATUS = 4'h8;
  localparam logic [3:0] REG_EVT_CLEAR  = 4'h9;
  localparam logic [3:0] REG_EVT_ENABLE = 4'hA;
  localparam logic [3:0] REG_NONE       = 4'hF;

  // ****************************************
  // Field layout and masks
  // ****************************************
  localparam int MULTI_VECTOR_SELECT_BIT     = 12;
  localparam int TPC_LSB      = 8;
  localparam int EXT_POL_LSB  = 0;
  localparam int STAT_LVL_LSB = 8;
  localparam int STAT_VEC_LSB = 0;
  localparam int PRIO_LSB     = 2;
  localparam int SUB_LSB      = 0;
  localparam int BYTE_W       = 8;
  localparam logic [31:0] MASK_CONTROL = 32'h0000171F;
  localparam logic [31:0] MASK_STATUS  = 32'h0000073F;
  localparam logic [31:0] MASK_PRIO    = 32'h1F1F1F1F;
  localparam logic [31:0] MASK_FULL    = 32'hFFFFFFFF;
  localparam logic [31:0] MASK_FLAGS   = 32'h001FFFFF;
  localparam logic [31:0] RST_ZERO     = 32'h00000000;
  localparam logic [2:0]  TPC_OFF      = 3'h0;
  localparam logic [2:0]  TPC_ONLY_ONE = 3'h1;
  localparam logic [2:0]  LEVEL_NONE   = 3'h0;

  // Event bits
  localparam int EV_PRESENT = 0;
  localparam int EV_LOAD    = 1;
  localparam int EV_EXPIRE  = 2;

  localparam logic HRESP_OKAY = 1'b0;
  localparam int   HTRANS_ACT = 1;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DATA = 2'b10
  } bus_state_t;

endpackage

// [vic_prio_if.sv]
`timescale 1ns/1ps
interface vic_prio_if #(
  parameter int NSRC = 21
);
  logic [NSRC-1:0] active;
  logic [2:0]      level [NSRC];
  logic [1:0]      sub   [NSRC];
  logic            win_valid;
  logic [5:0]      win_index;
  logic [2:0]      win_level;

  modport ctrl (
    output active,
    output level,
    output sub,
    input  win_valid,
    input  win_index,
    input  win_level
  );

  modport resolver (
    input  active,
    input  level,
    input  sub,
    output win_valid,
    output win_index,
    output win_level
  );
endinterface

// [vic_prio_resolver.sv]
`timescale 1ns/1ps
module vic_prio_resolver #(
  parameter int NSRC = 21
) (
  input  wire logic  hclk,
  input  wire logic  hresetn,
  vic_prio_if.resolver pif
);

  logic       best_valid;
  logic [5:0] best_index;
  logic [4:0] best_key;

  // ****************************************
  // Highest group priority, then subpriority
  // ****************************************
  // Strict compare keeps the lowest index on a tie, giving natural order.
  always_comb begin
    best_valid = 1'b0;
    best_index = '0;
    best_key   = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (pif.active[i] && pif.level[i] != vic_pkg::LEVEL_NONE &&
          (!best_valid || {pif.level[i], pif.sub[i]} > best_key)) begin
        best_valid = 1'b1;
        best_index = 6'(i);
        best_key   = {pif.level[i], pif.sub[i]};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pif.win_valid <= 1'b0;
      pif.win_index <= '0;
      pif.win_level <= '0;
    end else begin
      pif.win_valid <= best_valid;
      pif.win_index <= best_index;
      pif.win_level <= best_key[4:2];
    end
  end

endmodule

// [vectored_interrupt_controller.sv]
`timescale 1ns/1ps
// Function
// - Registers other than the event registers have clear, set, invert aliases at base plus 0x4, 0x8, 0xC.
// - Mode bit 1 selects multi-vector, 0 selects single-vector.
// - Proximity trigger field 000 disables the proximity timer.
// - Trigger field 010 to 111: priority at or below field starts timer.
// - Trigger field 001: only group priority 1 starts the timer.
// - Each external input has polarity bit: 1 rising, 0 falling edge.
// - Status word reports priority level of latest presented interrupt.
// - Status word low six bits report presented vector number.
// - Unimplemented upper status bits read zero and ignore writes.
// - All priority control registers reset to zero.
// - A qualifying interrupt loads the proximity timer from its reload word.
// - A request flag reads 1 once its source raised a request.
module vectored_interrupt_controller #(
  parameter logic [2:0] EXT_PRIO = 3'h1
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic [15:0] src_req,
  input  wire logic [4:0]  ext_irq_pin,
  input  wire logic        cpu_ack,
  output logic             cpu_irq_req,
  output logic [5:0]       cpu_vector,
  output logic [2:0]       cpu_level,
  output logic             irq
);

  localparam int NSRC = vic_pkg::NUM_SRC;

  if (EXT_PRIO == vic_pkg::LEVEL_NONE) begin : g_bad_prio
    $error("EXT_PRIO of zero would keep external inputs from ever presenting");
  end

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic [31:0] apply_alias(logic [31:0] old, logic [31:0] d,
                                              logic [1:0] kind);
    logic [31:0] r;
    r = d;
    unique case (kind)
      vic_pkg::ALIAS_NONE: r = d;
      vic_pkg::ALIAS_CLR:  r = old & ~d;
      vic_pkg::ALIAS_SET:  r = old | d;
      vic_pkg::ALIAS_INV:  r = old ^ d;
    endcase
    return r;
  endfunction

  function automatic logic [3:0] reg_index(logic [15:0] a);
    logic [3:0] id;
    id = vic_pkg::REG_NONE;
    if (a[1:0] == 2'h0) begin
      case (a[15:4])
        vic_pkg::OFF_CONTROL[15:4]:    id = vic_pkg::REG_CONTROL;
        vic_pkg::OFF_STATUS[15:4]:     id = vic_pkg::REG_STATUS;
        vic_pkg::OFF_RELOAD[15:4]:     id = vic_pkg::REG_RELOAD;
        vic_pkg::OFF_FLAGS[15:4]:      id = vic_pkg::REG_FLAGS;
        vic_pkg::OFF_PRIO_7[15:4]:     id = vic_pkg::REG_PRIO_7;
        vic_pkg::OFF_PRIO_8[15:4]:     id = vic_pkg::REG_PRIO_8;
        vic_pkg::OFF_PRIO_9[15:4]:     id = vic_pkg::REG_PRIO_9;
        vic_pkg::OFF_PRIO_10[15:4]:    id = vic_pkg::REG_PRIO_10;
        vic_pkg::OFF_EVT_STATUS[15:4]: id = vic_pkg::REG_EVT_STATUS;
        vic_pkg::OFF_EVT_CLEAR[15:4]:  id = vic_pkg::REG_EVT_CLEAR;
        vic_pkg::OFF_EVT_ENABLE[15:4]: id = vic_pkg::REG_EVT_ENABLE;
        default:                       id = vic_pkg::REG_NONE;
      endcase
      // Event registers have no aliases
      if (id >= vic_pkg::REG_EVT_STATUS && a[3:2] != vic_pkg::ALIAS_NONE) begin
        id = vic_pkg::REG_NONE;
      end
    end
    return id;
  endfunction

  function automatic logic qualifies(logic [2:0] tpc, logic [2:0] lvl);
    logic q;
    if (tpc == vic_pkg::TPC_OFF) begin
      q = 1'b0;
    end else if (tpc == vic_pkg::TPC_ONLY_ONE) begin
      q = (lvl == vic_pkg::TPC_ONLY_ONE);
    end else begin
      q = (lvl <= tpc);
    end
    return q;
  endfunction

  // ****************************************
  // State
  // ****************************************
  vic_pkg::bus_state_t bus_state;
  logic [15:0] cap_addr;
  logic        cap_write;
  logic [31:0] control_word;
  logic [31:0] status_word;
  logic [31:0] reload_word;
  logic [31:0] flag_word;
  logic [31:0] prio_word [vic_pkg::NUM_PRIO];
  logic [vic_pkg::NUM_EV-1:0] evt_status;
  logic [vic_pkg::NUM_EV-1:0] evt_enable;
  logic [31:0] prox_count;
  logic [4:0]  ext_prev;
  logic [5:0]  cur_index;

  logic        wr_strobe;
  logic        rd_strobe;
  logic [3:0]  acc_id;
  logic [1:0]  acc_alias;
  logic [31:0] rd_word;
  logic        present_new;
  logic        prox_start;
  logic        prox_expire;
  logic [4:0]  ext_edge;
  logic [31:0] flag_set;
  logic [31:0] flag_clr;
  logic [vic_pkg::NUM_EV-1:0] ev_vec;
  logic [vic_pkg::NUM_EV-1:0] next_evt_status;
  logic        multi_vector_select;
  logic [2:0]  tpc;

  vic_prio_if #(.NSRC(NSRC)) pif ();

  vic_prio_resolver #(.NSRC(NSRC)) u_resolver (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pif     (pif)
  );

  assign multi_vector_select      = control_word[vic_pkg::MULTI_VECTOR_SELECT_BIT];
  assign tpc       = control_word[vic_pkg::TPC_LSB +: 3];
  assign acc_id    = reg_index(cap_addr);
  assign acc_alias = cap_addr[3:2];
  assign wr_strobe = (bus_state == vic_pkg::BUS_DATA) && cap_write;
  assign rd_strobe = (bus_state == vic_pkg::BUS_DATA) && !cap_write;

  // ****************************************
  // AHB-Lite slave, one wait state per transfer
  // ****************************************
  // The wait state lets read data come straight from a flip-flop.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state <= vic_pkg::BUS_IDLE;
      hreadyout <= 1'b1;
      cap_addr  <= '0;
      cap_write <= 1'b0;
    end else begin
      unique case (bus_state)
        vic_pkg::BUS_IDLE: begin
          if (hsel && htrans[vic_pkg::HTRANS_ACT] && hready) begin
            cap_addr  <= haddr[15:0];
            cap_write <= hwrite;
            hreadyout <= 1'b0;
            bus_state <= vic_pkg::BUS_DATA;
          end
        end
        vic_pkg::BUS_DATA: begin
          hreadyout <= 1'b1;
          bus_state <= vic_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= vic_pkg::HRESP_OKAY;
    end else begin
      hresp <= vic_pkg::HRESP_OKAY;
    end
  end

  // Alias reads return the base register; unmapped reads return zero
  always_comb begin
    rd_word = vic_pkg::RST_ZERO;
    unique case (acc_id)
      vic_pkg::REG_CONTROL:    rd_word = control_word;
      vic_pkg::REG_STATUS:     rd_word = status_word;
      vic_pkg::REG_RELOAD:     rd_word = reload_word;
      vic_pkg::REG_FLAGS:      rd_word = flag_word;
      vic_pkg::REG_PRIO_7:     rd_word = prio_word[0];
      vic_pkg::REG_PRIO_8:     rd_word = prio_word[1];
      vic_pkg::REG_PRIO_9:     rd_word = prio_word[2];
      vic_pkg::REG_PRIO_10:    rd_word = prio_word[3];
      vic_pkg::REG_EVT_STATUS: rd_word = 32'(evt_status);
      vic_pkg::REG_EVT_ENABLE: rd_word = 32'(evt_enable);
      default:                 rd_word = vic_pkg::RST_ZERO;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= vic_pkg::RST_ZERO;
    end else if (rd_strobe) begin
      hrdata <= rd_word;
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      control_word <= vic_pkg::RST_ZERO;
    end else if (wr_strobe && acc_id == vic_pkg::REG_CONTROL) begin
      control_word <= apply_alias(control_word, hwdata, acc_alias)
                      & vic_pkg::MASK_CONTROL;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reload_word <= vic_pkg::RST_ZERO;
    end else if (wr_strobe && acc_id == vic_pkg::REG_RELOAD) begin
      reload_word <= apply_alias(reload_word, hwdata, acc_alias);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int r = 0; r < vic_pkg::NUM_PRIO; r++) begin
        prio_word[r] <= vic_pkg::RST_ZERO;
      end
    end else if (wr_strobe && acc_id >= vic_pkg::REG_PRIO_7 &&
                 acc_id <= vic_pkg::REG_PRIO_10) begin
      prio_word[acc_id[1:0]] <= apply_alias(prio_word[acc_id[1:0]], hwdata, acc_alias)
                                & vic_pkg::MASK_PRIO;
    end
  end

  // Hardware capture wins over a software write in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_word <= vic_pkg::RST_ZERO;
    end else if (present_new) begin
      status_word <= vic_pkg::RST_ZERO;
      status_word[vic_pkg::STAT_LVL_LSB +: 3] <= pif.win_level;
      status_word[vic_pkg::STAT_VEC_LSB +: 6] <= pif.win_index;
    end else if (wr_strobe && acc_id == vic_pkg::REG_STATUS) begin
      status_word <= apply_alias(status_word, hwdata, acc_alias)
                     & vic_pkg::MASK_STATUS;
    end
  end

  // ****************************************
  // Request sources and flags
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_prev <= '0;
    end else begin
      ext_prev <= ext_irq_pin;
    end
  end

  always_comb begin
    for (int k = 0; k < vic_pkg::NUM_EXT; k++) begin
      if (control_word[vic_pkg::EXT_POL_LSB + k]) begin
        ext_edge[k] = ext_irq_pin[k] && !ext_prev[k];
      end else begin
        ext_edge[k] = !ext_irq_pin[k] && ext_prev[k];
      end
    end
  end

  always_comb begin
    flag_set = {11'h000, ext_edge, src_req};
    flag_clr = vic_pkg::RST_ZERO;
    if (cpu_ack && cpu_irq_req) begin
      flag_clr[cur_index[4:0]] = 1'b1;
    end
  end

  // A request arriving with a clear is kept: set is applied last
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_word <= vic_pkg::RST_ZERO;
    end else if (wr_strobe && acc_id == vic_pkg::REG_FLAGS) begin
      flag_word <= ((apply_alias(flag_word, hwdata, acc_alias) & ~flag_clr) | flag_set)
                   & vic_pkg::MASK_FLAGS;
    end else begin
      flag_word <= ((flag_word & ~flag_clr) | flag_set) & vic_pkg::MASK_FLAGS;
    end
  end

  // ****************************************
  // Feed to the resolver
  // ****************************************
  always_comb begin
    pif.active = flag_word[NSRC-1:0];
    for (int j = 0; j < NSRC; j++) begin
      pif.level[j] = EXT_PRIO;
      pif.sub[j]   = 2'h0;
      if (j < vic_pkg::NUM_PERIPH) begin
        // Slot 0 of each word sits in its top byte
        pif.level[j] = prio_word[j / vic_pkg::SLOTS]
          [(vic_pkg::SLOTS - 1 - j % vic_pkg::SLOTS) * vic_pkg::BYTE_W
           + vic_pkg::PRIO_LSB +: 3];
        pif.sub[j] = prio_word[j / vic_pkg::SLOTS]
          [(vic_pkg::SLOTS - 1 - j % vic_pkg::SLOTS) * vic_pkg::BYTE_W
           + vic_pkg::SUB_LSB +: 2];
      end
    end
  end

  // ****************************************
  // Presentation to the core
  // ****************************************
  assign present_new = pif.win_valid && (!cpu_irq_req || pif.win_index != cur_index);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_irq_req <= 1'b0;
      cpu_level   <= '0;
      cpu_vector  <= '0;
      cur_index   <= '0;
    end else begin
      cpu_irq_req <= pif.win_valid;
      cpu_level   <= pif.win_level;
      cur_index   <= pif.win_index;
      // Single-vector mode sends every request to vector zero
      cpu_vector  <= multi_vector_select ? pif.win_index : 6'h00;
    end
  end

  // ****************************************
  // Proximity timer
  // ****************************************
  assign prox_start  = present_new && qualifies(tpc, pif.win_level);
  assign prox_expire = !prox_start && tpc != vic_pkg::TPC_OFF && prox_count == 32'h00000001;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prox_count <= vic_pkg::RST_ZERO;
    end else if (prox_start) begin
      prox_count <= reload_word;
    end else if (tpc == vic_pkg::TPC_OFF) begin
      prox_count <= vic_pkg::RST_ZERO;
    end else if (prox_count != vic_pkg::RST_ZERO) begin
      prox_count <= prox_count - 32'h00000001;
    end
  end

  // ****************************************
  // Event status, enable and interrupt line
  // ****************************************
  always_comb begin
    ev_vec                     = '0;
    ev_vec[vic_pkg::EV_PRESENT] = present_new;
    ev_vec[vic_pkg::EV_LOAD]    = prox_start;
    ev_vec[vic_pkg::EV_EXPIRE]  = prox_expire;
    next_evt_status = evt_status;
    if (wr_strobe && acc_id == vic_pkg::REG_EVT_CLEAR) begin
      next_evt_status = evt_status & ~hwdata[vic_pkg::NUM_EV-1:0];
    end
    next_evt_status = next_evt_status | ev_vec;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_status <= '0;
    end else begin
      evt_status <= next_evt_status;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_enable <= '0;
    end else if (wr_strobe && acc_id == vic_pkg::REG_EVT_ENABLE) begin
      evt_enable <= hwdata[vic_pkg::NUM_EV-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_evt_status & evt_enable);
    end
  end

endmodule

// [vic_checker.sv]
`timescale 1ns/1ps
module vic_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic [15:0] src_req,
  input wire logic [4:0]  ext_irq_pin,
  input wire logic        cpu_ack,
  input wire logic        cpu_irq_req,
  input wire logic [5:0]  cpu_vector,
  input wire logic [2:0]  cpu_level,
  input wire logic        irq
);
  // ****************************************
  // Read tracking and properties
  // ****************************************
  logic        taken;
  logic        rd_pend;
  logic [15:0] rd_addr;
  logic [15:0] rd_base;

  assign taken   = hsel && htrans[1] && hready && hreadyout;
  assign rd_base = {rd_addr[15:4], 4'h0};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pend <= 1'b0;
      rd_addr <= 16'h0000;
    end else if (taken) begin
      rd_pend <= !hwrite;
      rd_addr <= haddr[15:0];
    end else if (hreadyout) begin
      rd_pend <= 1'b0;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_taken;
    hsel && htrans[1] && hready && hreadyout;
  endsequence
  sequence s_answer;
    !hreadyout ##1 hreadyout;
  endsequence

  property p_wait_state;
    s_taken |=> s_answer;
  endproperty
  a_wait_state: assert property (p_wait_state) else $error("bad wait state");
  property p_idle_ready;
    hreadyout && !taken |=> hreadyout;
  endproperty
  a_idle_ready: assert property (p_idle_ready) else $error("ready dropped idle");
  property p_okay;
    hresp == vic_pkg::HRESP_OKAY;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_status_mask;
    rd_pend && hreadyout && rd_base == vic_pkg::OFF_STATUS |-> !(hrdata & ~vic_pkg::MASK_STATUS);
  endproperty
  a_status_mask: assert property (p_status_mask) else $error("status upper bits");
  property p_ctrl_mask;
    rd_pend && hreadyout && rd_base == vic_pkg::OFF_CONTROL |-> !(hrdata & ~vic_pkg::MASK_CONTROL);
  endproperty
  a_ctrl_mask: assert property (p_ctrl_mask) else $error("control spare bits");
  property p_prio_mask;
    rd_pend && hreadyout && rd_base >= vic_pkg::OFF_PRIO_7 && rd_base <= vic_pkg::OFF_PRIO_10
      |-> (hrdata & ~vic_pkg::MASK_PRIO) == 32'h0;
  endproperty
  a_prio_mask: assert property (p_prio_mask) else $error("priority spare bits");
  property p_level;
    cpu_irq_req |-> cpu_level != vic_pkg::LEVEL_NONE;
  endproperty
  a_level: assert property (p_level) else $error("level zero presented");
  property p_vector;
    cpu_irq_req |-> cpu_vector < 6'(vic_pkg::NUM_SRC);
  endproperty
  a_vector: assert property (p_vector) else $error("vector out of range");
  property p_reset_out;
    $rose(hresetn) |-> hreadyout && !cpu_irq_req && !irq;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs after reset");
endmodule

// [core_model.sv]
`timescale 1ns/1ps
module core_model (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       cpu_irq_req,
  input wire logic       ack_en,
  input wire logic [3:0] ack_delay,
  output logic           cpu_ack
);
  // ****************************************
  // Acknowledge after a delay
  // ****************************************
  // Gap keeps a stale winner from being acked twice
  logic [3:0] cnt;
  logic [1:0] gap;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_ack <= 1'b0;
      cnt     <= 4'h0;
      gap     <= 2'h0;
    end else begin
      cpu_ack <= 1'b0;
      if (gap != 2'h0) begin
        gap <= gap - 2'h1;
      end else if (cpu_irq_req && ack_en) begin
        if (cnt == ack_delay) begin
          cpu_ack <= 1'b1;
          cnt     <= 4'h0;
          gap     <= 2'h3;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end else begin
        cnt <= 4'h0;
      end
    end
  end
endmodule

// [tb.sv]
`timescale 1ns/1ps
module tb;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, cpu_ack, cpu_irq_req, irq, ack_en;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, cpu_level;
  logic [15:0] src_req;
  logic [4:0]  ext_irq_pin;
  logic [5:0]  cpu_vector;
  logic [3:0]  ack_delay;
  int          failures, comparisons;
  logic [2:0]  tpc_v [6] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h7};
  logic [2:0]  pri_v [6] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h7};
  logic        exp_v [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

  assign hready = hreadyout;
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  vectored_interrupt_controller dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .src_req(src_req), .ext_irq_pin(ext_irq_pin), .cpu_ack(cpu_ack),
    .cpu_irq_req(cpu_irq_req), .cpu_vector(cpu_vector), .cpu_level(cpu_level), .irq(irq));
  core_model core (.hclk(hclk), .hresetn(hresetn), .cpu_irq_req(cpu_irq_req),
    .ack_en(ack_en), .ack_delay(ack_delay), .cpu_ack(cpu_ack));

  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic stop_test;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic xfer(input logic [15:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
    int n = 0;
    htrans <= 2'h2;
    haddr  <= {16'h0000, a};
    hwrite <= w;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    r = hrdata;
    if (n >= 50) begin
      failures++;
      stop_test();
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] want);
    logic [31:0] r;
    xfer(a, 1'b0, 32'h0, r);
    check(r, want);
  endtask
  task automatic pulse_usb;
    src_req <= 16'h0002;
    @(posedge hclk);
    src_req <= 16'h0000;
  endtask
  task automatic wait_req;
    int n = 0;
    while (cpu_irq_req !== 1'b1 && n < 20) begin @(posedge hclk); n++; end
    if (n >= 20) begin
      failures++;
      stop_test();
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    hresetn = 1'b0; hsel = 1'b1; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; src_req = 16'h0; ext_irq_pin = 5'h0;
    ack_en = 1'b0; ack_delay = 4'h0; failures = 0; comparisons = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 4; i++) rd(vic_pkg::OFF_PRIO_7 + 16'(i * 16), 32'h0);
    rd(vic_pkg::OFF_FLAGS, 32'h0);
    wr(vic_pkg::OFF_PRIO_8, 32'hFFFFFFFF);
    rd(vic_pkg::OFF_PRIO_8, 32'h1F1F1F1F);
    wr(vic_pkg::OFF_PRIO_8 + 16'h4, 32'h0F0F0F0F);
    rd(vic_pkg::OFF_PRIO_8, 32'h10101010);
    wr(vic_pkg::OFF_PRIO_8 + 16'h8, 32'h00000003);
    rd(vic_pkg::OFF_PRIO_8, 32'h10101013);
    wr(vic_pkg::OFF_PRIO_8 + 16'hC, 32'h11000001);
    rd(vic_pkg::OFF_PRIO_8, 32'h01101012);
    wr(vic_pkg::OFF_STATUS, 32'hFFFFFFFF);
    rd(vic_pkg::OFF_STATUS, 32'h0000073F);
    wr(vic_pkg::OFF_CONTROL, 32'hFFFFFFFF);
    rd(vic_pkg::OFF_CONTROL, 32'h0000171F);
    rd(16'h1FF0, 32'h0);
    wr(vic_pkg::OFF_CONTROL, 32'h00001000);
    wr(vic_pkg::OFF_PRIO_7, 32'h00150000);
    wr(vic_pkg::OFF_STATUS, 32'h0);
    pulse_usb();
    wait_req();
    check({26'h0, cpu_vector}, 32'h1);
    check({29'h0, cpu_level}, 32'h5);
    rd(vic_pkg::OFF_FLAGS, 32'h2);
    rd(vic_pkg::OFF_STATUS, 32'h00000501);
    ack_en <= 1'b1;
    repeat (8) @(posedge hclk);
    check({31'h0, cpu_irq_req}, 32'h0);
    wr(vic_pkg::OFF_CONTROL, 32'h0);
    pulse_usb();
    wait_req();
    check({26'h0, cpu_vector}, 32'h0);
    repeat (8) @(posedge hclk);
    ack_en <= 1'b0;
    wr(vic_pkg::OFF_CONTROL, 32'h00000015);
    ext_irq_pin <= 5'h1F;
    repeat (3) @(posedge hclk);
    rd(vic_pkg::OFF_FLAGS, 32'h00150000);
    ext_irq_pin <= 5'h00;
    repeat (3) @(posedge hclk);
    rd(vic_pkg::OFF_FLAGS, 32'h001F0000);
    wr(vic_pkg::OFF_FLAGS, 32'h0);
    wr(vic_pkg::OFF_RELOAD, 32'h00000008);
    wr(vic_pkg::OFF_EVT_ENABLE, 32'h2);
    ack_en <= 1'b1;
    ack_delay <= 4'h3;
    repeat (6) @(posedge hclk);
    for (int i = 0; i < 6; i++) begin
      wr(vic_pkg::OFF_EVT_CLEAR, 32'h7);
      wr(vic_pkg::OFF_CONTROL, {21'h0, tpc_v[i], 8'h00});
      wr(vic_pkg::OFF_PRIO_7, {11'h0, pri_v[i], 18'h0});
      pulse_usb();
      wait_req();
      check({31'h0, irq}, {31'h0, exp_v[i]});
      rd(vic_pkg::OFF_EVT_STATUS, {30'h0, exp_v[i], 1'b1});
      repeat (8) @(posedge hclk);
    end
    wr(vic_pkg::OFF_EVT_ENABLE, 32'h0);
    repeat (2) @(posedge hclk);
    check({31'h0, irq}, 32'h0);
    wr(vic_pkg::OFF_EVT_ENABLE, 32'h2);
    repeat (2) @(posedge hclk);
    check({31'h0, irq}, 32'h1);
    wr(vic_pkg::OFF_EVT_CLEAR, 32'h7);
    wr(vic_pkg::OFF_EVT_ENABLE, 32'h4);
    check({31'h0, irq}, 32'h0);
    pulse_usb();
    wait_req();
    check({31'h0, irq}, 32'h0);
    repeat (10) @(posedge hclk);
    check({31'h0, irq}, 32'h1);
    stop_test();
  end
endmodule

bind vectored_interrupt_controller vic_checker chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
  .hresp(hresp), .src_req(src_req), .ext_irq_pin(ext_irq_pin), .cpu_ack(cpu_ack),
  .cpu_irq_req(cpu_irq_req), .cpu_vector(cpu_vector), .cpu_level(cpu_level), .irq(irq));
